// [rtl/aowdt_counter.v]
`timescale 1ns/100ps
module aowdt_counter (
  input wire sysClk,
  input wire arstN,
  input wire subTick,
  input wire clear,
  input wire [2:0] timeoutSelect,
  output reg overflow
);
  reg [18:0] count;
  // tap bit for a select code
  function [4:0] tapBit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tapBit = 5'd8;
        3'h1: tapBit = 5'd10;
        3'h2: tapBit = 5'd12;
        3'h3: tapBit = 5'd14;
        3'h4: tapBit = 5'd15;
        3'h5: tapBit = 5'd16;
        3'h6: tapBit = 5'd17;
        default: tapBit = 5'd18;
      endcase
    end
  endfunction
  wire tapHit = count[tapBit(timeoutSelect)];
  // counts only sub clock ticks, never system cycles (see R01)
  // no enable input exists, so it cannot be stopped (see R03)
  always @(posedge sysClk or negedge arstN)
  begin
    if (!arstN)
    begin
      count <= 19'h00000;
      overflow <= 1'b0;
    end
    else if (clear)
    begin
      count <= 19'h00000; // see R14
      overflow <= 1'b0;
    end
    else if (tapHit)
    begin
      count <= 19'h00000; // restart after overflow (see R14)
      overflow <= 1'b1; // see R02
    end
    else
    begin
      if (subTick)
        count <= count + 19'h00001;
      overflow <= 1'b0;
    end
  end
endmodule

// [rtl/aowdt_regs.vh]
`ifndef AOWDT_REGS_VH
`define AOWDT_REGS_VH
// register byte addresses
`define AOWDT_ADDR_WDCTL 4'h0
`define AOWDT_ADDR_SYSCTL 4'h4
`define AOWDT_ADDR_STAT 4'h8
`define AOWDT_ADDR_MASK 4'hc
`define AOWDT_ADDR_CORE 5'h10
// watchdog_control fields and reset value
`define AOWDT_WDCTL_RESET 8'h53
`define AOWDT_KEY_LSB 3
`define AOWDT_KEY_A 5'h15
`define AOWDT_KEY_B 5'h0a
// system_control fields
`define AOWDT_KEYFLAG_BIT 0
`define AOWDT_TOFLAG_BIT 1
`define AOWDT_PDFLAG_BIT 2
// status / mask bits
`define AOWDT_EV_TIMEOUT 0
`define AOWDT_EV_KEYRST 1
`define AOWDT_EV_WAKE 2
// timing
`define AOWDT_SYS_HZ 125000000
`define AOWDT_SUB_HZ 32000
`define AOWDT_SUB_DIV (`AOWDT_SYS_HZ / `AOWDT_SUB_HZ)
`define AOWDT_DEBOUNCE_TICKS 2
`define AOWDT_RESET_PULSE 3'h4
`endif

// [rtl/aowdt_sub_tick.v]
`timescale 1ns/100ps
`include "aowdt_regs.vh"
module aowdt_sub_tick #(
  parameter DIV = `AOWDT_SUB_DIV
) (
  input wire sysClk,
  input wire arstN,
  output reg subTick
);
  reg [15:0] count;
  // divider models the low-speed oscillator as an enable pulse
  always @(posedge sysClk or negedge arstN)
  begin
    if (!arstN)
    begin
      count <= 16'h0000;
      subTick <= 1'b0;
    end
    else if (count == DIV[15:0] - 16'h0001)
    begin
      count <= 16'h0000;
      subTick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      subTick <= 1'b0;
    end
  end
endmodule

// [rtl/aowdt_top.v]
// What this block does
// (R01) watchdog counts only sub clock ticks
// (R02) select code picks 2^8..2^18 timeout
// (R03) watchdog cannot be turned off
// (R04) reset loads control with 01010011
// (R05) sleep timeout keeps control register unchanged
// (R06) bad key resets on the 2nd sub tick
// (R07) key reset sets flag, software clears
// (R08) normal overflow gives full reset, timeout flag
// (R09) sleep overflow resets only pc and sp
// (R10) key reset, clear, halt clear counter
// (R11) software clears before timeout expires
// (R12) halt clears watchdog, sets pd, clears to
// (R13) sleep overflow wakes device
// (R14) free counter restarts on clear, tap overflow
`timescale 1ns/100ps
`include "aowdt_regs.vh"
module aowdt_top #(
  parameter SUB_DIV = `AOWDT_SUB_DIV
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire clearWatchdogInstr,
  input wire haltInstr,
  output reg fullReset,
  output reg pcSpReset,
  output reg wakeUp,
  output reg powerDown,
  output wire irq
);
  reg [7:0] watchdogControl;
  reg keyResetFlag;
  reg timeoutFlag;
  reg powerDownFlag;
  reg [2:0] status;
  reg [2:0] mask;
  reg awHeld;
  reg wHeld;
  reg [31:0] awAddr;
  reg [31:0] wData;
  reg wStrb0;
  reg [1:0] debounce;
  reg [2:0] rstCount;
  wire subTick;
  wire overflow;
  wire keyBad;
  wire keyReset;
  wire doWrite;
  wire [3:0] wAddr;
  wire counterClear;
  wire [2:0] events;
  wire ctlWrite;

  aowdt_sub_tick #(
    .DIV(SUB_DIV)
  ) uTick (
    .sysClk(sys_clk),
    .arstN(arst_n),
    .subTick(subTick)
  );

  // clear on key reset, clear instruction, or halt
  assign counterClear = keyReset | clearWatchdogInstr | haltInstr; // see R10

  aowdt_counter uCount (
    .sysClk(sys_clk),
    .arstN(arst_n),
    .subTick(subTick),
    .clear(counterClear),
    .timeoutSelect(watchdogControl[2:0]),
    .overflow(overflow)
  );

  // key check: only two patterns keep running
  function keyOk;
    input [4:0] key;
    begin
      keyOk = (key == `AOWDT_KEY_A) || (key == `AOWDT_KEY_B);
    end
  endfunction
  assign keyBad = !keyOk(watchdogControl[7:`AOWDT_KEY_LSB]); // see R06

  // debounce across sub ticks so a glitch on the key is not fatal
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      debounce <= 2'h0;
    else if (!keyBad)
      debounce <= 2'h0;
    else if (subTick && debounce != `AOWDT_DEBOUNCE_TICKS)
      debounce <= debounce + 2'h1; // see R06
  end
  assign keyReset = keyBad && subTick &&
    (debounce == `AOWDT_DEBOUNCE_TICKS - 1);

  // write channel: address and data taken in either order
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wAddr = awAddr[3:0];
  assign ctlWrite = doWrite && wStrb0 && awAddr[31:4] == 28'h0000000 &&
    wAddr == `AOWDT_ADDR_WDCTL;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 32'h00000000;
      wData <= 32'h00000000;
      wStrb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb0 <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr[31:4] == 28'h0000000 && awAddr[1:0] == 2'h0)
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control register: reset value carries valid key and 2^14 code
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      watchdogControl <= `AOWDT_WDCTL_RESET; // see R04
    else if (keyReset || (fullReset == 1'b0 && overflow && !powerDown))
      watchdogControl <= `AOWDT_WDCTL_RESET; // see R04
    else if (ctlWrite)
      watchdogControl <= wData[7:0];
    // overflow while powered down leaves it alone (see R05)
  end

  // system flags; hardware set wins over software clear
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      keyResetFlag <= 1'b0;
      timeoutFlag <= 1'b0;
      powerDownFlag <= 1'b0;
      powerDown <= 1'b0;
    end
    else
    begin
      if (keyReset)
        keyResetFlag <= 1'b1; // see R07
      else if (doWrite && wStrb0 && awAddr[31:4] == 28'h0000000 &&
        wAddr == `AOWDT_ADDR_SYSCTL && !wData[`AOWDT_KEYFLAG_BIT])
        keyResetFlag <= 1'b0; // see R07
      if (overflow)
        timeoutFlag <= 1'b1; // see R08
      else if (haltInstr)
        timeoutFlag <= 1'b0; // see R12
      if (haltInstr)
        powerDownFlag <= 1'b1; // see R12
      else if (clearWatchdogInstr)
        powerDownFlag <= 1'b0;
      if (haltInstr)
        powerDown <= 1'b1;
      else if (overflow)
        powerDown <= 1'b0; // woken by overflow (see R13)
    end
  end

  // reset pulses and wake strobe
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstCount <= 3'h0;
      fullReset <= 1'b0;
      pcSpReset <= 1'b0;
      wakeUp <= 1'b0;
    end
    else
    begin
      wakeUp <= overflow && powerDown; // see R13
      pcSpReset <= overflow && powerDown; // see R09
      if ((overflow && !powerDown) || keyReset)
      begin
        rstCount <= `AOWDT_RESET_PULSE; // see R08
        fullReset <= 1'b1;
      end
      else if (rstCount != 3'h0)
        rstCount <= rstCount - 3'h1;
      else
        fullReset <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign events = {overflow && powerDown, keyReset, overflow};
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= 3'h0;
      mask <= 3'h0;
    end
    else
    begin
      if (doWrite && wStrb0 && awAddr[31:4] == 28'h0000000 &&
        wAddr == `AOWDT_ADDR_STAT)
        status <= (status & ~wData[2:0]) | events;
      else
        status <= status | events;
      if (doWrite && wStrb0 && awAddr[31:4] == 28'h0000000 &&
        wAddr == `AOWDT_ADDR_MASK)
        mask <= wData[2:0];
    end
  end
  assign irq = |(status & mask);

  // read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr[31:4] != 28'h0000000 || s_axi_araddr[1:0] != 2'h0)
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
      else if (s_axi_araddr[3:0] == `AOWDT_ADDR_WDCTL)
        s_axi_rdata <= {24'h000000, watchdogControl};
      else if (s_axi_araddr[3:0] == `AOWDT_ADDR_SYSCTL)
        s_axi_rdata <= {29'h00000000, powerDownFlag, timeoutFlag,
          keyResetFlag};
      else if (s_axi_araddr[3:0] == `AOWDT_ADDR_STAT)
        s_axi_rdata <= {29'h00000000, status};
      else
        s_axi_rdata <= {29'h00000000, mask};
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// [testbench/aowdt_core_model.sv]
`timescale 1ns/100ps
// core side: issues one-cycle clear and halt instruction pulses
module aowdt_core_model (
  input wire logic sys_clk,
  output logic clearWatchdogInstr,
  output logic haltInstr
);
  initial
  begin
    clearWatchdogInstr = 1'b0;
    haltInstr = 1'b0;
  end

  // clear n times, gap idle cycles between pulses, shorter than the timeout
  task automatic kick(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge sys_clk);
      clearWatchdogInstr <= 1'b1;
      @(posedge sys_clk);
      clearWatchdogInstr <= 1'b0;
    end
  endtask

  // extra edge at the end so registered effects have landed
  task automatic halt();
    @(posedge sys_clk);
    haltInstr <= 1'b1;
    @(posedge sys_clk);
    haltInstr <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// [testbench/aowdt_properties.sv]
`timescale 1ns/100ps
module aowdt_checker #(
  parameter SUB_DIV = 4
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire haltInstr,
  input wire fullReset,
  input wire pcSpReset,
  input wire wakeUp,
  input wire powerDown
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_pulse_len: assert property ($rose(fullReset) |-> fullReset[*5] ##1 !fullReset)
    else $error("full reset pulse length wrong");
  chk_wake_pair: assert property (pcSpReset |-> wakeUp && !fullReset)
    else $error("sleep overflow not paired with wake");
  chk_pcsp_single: assert property (pcSpReset |=> !pcSpReset)
    else $error("pc/sp reset longer than one cycle");
  chk_pcsp_asleep: assert property ($rose(pcSpReset) |-> $past(powerDown))
    else $error("pc/sp reset outside power down");
  chk_halt_pd: assert property (haltInstr |=> powerDown)
    else $error("halt did not enter power down");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule

bind aowdt_top aowdt_checker #(.SUB_DIV(SUB_DIV)) chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .haltInstr(haltInstr), .fullReset(fullReset), .pcSpReset(pcSpReset),
  .wakeUp(wakeUp), .powerDown(powerDown)
);

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0, arst_n = 1'b0;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData, rdv;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, clr, hlt;
  logic fullReset, pcSpReset, wakeUp, powerDown, irq;
  logic [1:0] bResp, rResp, rrv;
  int failures = 0, comparisons = 0, frCnt = 0, t;

  aowdt_core_model core (.sys_clk(sys_clk), .clearWatchdogInstr(clr),
    .haltInstr(hlt));
  // short sub clock divider keeps the 2^8 timeout in reach
  aowdt_top #(.SUB_DIV(4)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .clearWatchdogInstr(clr),
    .haltInstr(hlt), .fullReset(fullReset), .pcSpReset(pcSpReset),
    .wakeUp(wakeUp), .powerDown(powerDown), .irq(irq));

  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge fullReset) frCnt++;

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (t = 0; t < 200 && !(bValid === 1'b1 && bReady); t++)
    begin
      @(posedge sys_clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
    end
    if (t >= 200) failures++;
    chk("bresp", {30'h0, er}, {30'h0, bResp});
    bReady <= 1'b0;
  endtask

  // read: rready held from the request until rvalid is sampled
  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (t = 0; t < 200 && !(rValid === 1'b1 && rReady); t++)
    begin
      @(posedge sys_clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
    end
    if (t >= 200) failures++;
    rdv = rData;
    rrv = rResp;
    rReady <= 1'b0;
  endtask

  // whole run is near 6000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(32'h0); chk("ctl", 32'h53, rdv);
    rd(32'h4); chk("sys", 32'h0, rdv);
    rd(32'h20); chk("bad rresp", 32'h2, {30'h0, rrv});
    wr(32'h24, 32'h1, 2'h2);
    wr(32'hc, 32'h7, 2'h0);
    wr(32'h0, 32'ha8, 2'h0);
    rd(32'h0); chk("ctl", 32'ha8, rdv);
    core.kick(6, 600);
    chk("no reset", 32'h0, frCnt);
    for (t = 0; t < 1200 && fullReset !== 1'b1; t++) @(posedge sys_clk);
    chk("timeout", 32'h1, t > 1010 && t < 1040);
    rd(32'h4); chk("sys to", 32'h2, rdv);
    rd(32'h0); chk("ctl reload", 32'h53, rdv);
    chk("irq", 32'h1, irq);
    wr(32'hc, 32'h0, 2'h0); chk("irq masked", 32'h0, irq);
    wr(32'hc, 32'h7, 2'h0); chk("irq", 32'h1, irq);
    wr(32'h8, 32'h7, 2'h0); chk("irq clr", 32'h0, irq);
    wr(32'h0, 32'h50, 2'h0);
    core.halt();
    chk("pd", 32'h1, powerDown);
    rd(32'h4); chk("sys pd", 32'h4, rdv);
    for (t = 0; t < 1200 && pcSpReset !== 1'b1; t++) @(posedge sys_clk);
    chk("wake", 32'h1, wakeUp);
    chk("no full", 32'h1, frCnt);
    rd(32'h0); chk("ctl kept", 32'h50, rdv);
    rd(32'h4); chk("sys to", 32'h2, rdv & 32'h2);
    wr(32'h0, 32'h0, 2'h0);
    for (t = 0; t < 40 && fullReset !== 1'b1; t++) @(posedge sys_clk);
    chk("key delay", 32'h1, t >= 2 && t <= 16);
    rd(32'h4); chk("key flag", 32'h1, rdv & 32'h1);
    wr(32'h4, 32'h0, 2'h0);
    rd(32'h4); chk("flag clr", 32'h0, rdv & 32'h1);
    stop_test();
  end
endmodule
